// ===== hdl/supply_ctrl_pkg.sv
// package: constants, timing and carriers for the supply module controller
package supply_ctrl_pkg;

  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned LINE_CNT       = 6;
  // timing in microseconds, as specified
  localparam int unsigned RELEASE_MAX_US = 3_000;   // host release after request
  localparam int unsigned MEASURE_US     = 200_000; // device measurement time
  localparam int unsigned RETURN_MIN_US  = 1_000;   // drive back, earliest
  localparam int unsigned RETURN_MAX_US  = 4_000;   // drive back, latest
  localparam int unsigned CLK_PER_US     = CLK_HZ / 1_000_000;
  // release soon after request: well inside the longest window
  localparam int unsigned RELEASE_CYC    = CLK_PER_US * 10;
  localparam int unsigned MEASURE_CYC    = CLK_PER_US * MEASURE_US;
  // return in the middle of the window, rounded down
  localparam int unsigned RETURN_CYC     =
    CLK_PER_US * ((RETURN_MIN_US + RETURN_MAX_US) / 2);
  // timeout waiting for valid flag: twice the measurement time
  localparam int unsigned VALID_TO_CYC   = MEASURE_CYC * 2;

  // software register map (word index = byte address / 4)
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_SNAP   = 4'h8;
  // control fields
  localparam int unsigned CTRL_EN_LSB  = 0; // bits 5:0 enable per line
  localparam int unsigned CTRL_SHDN    = 8; // 1 = shutdown all
  localparam int unsigned CTRL_READ    = 9; // write 1 = start status read
  localparam int unsigned CTRL_POP_LSB = 16; // bits 21:16 populated mask
  localparam logic [5:0]  EN_RST       = 6'h3F;
  localparam logic [5:0]  POP_RST      = 6'h3F;
  // status fields
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_DONE  = 1;
  localparam int unsigned ST_TOUT  = 2;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  typedef struct packed {
    logic [5:0] o;
    logic [5:0] oe;
  } line_drv_s;

endpackage

// ===== hdl/sync2.sv
// two-flop synchroniser for a vector of asynchronous pins
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // next values: stage one only feeds stage two
  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule

// ===== hdl/supply_host_ctrl.sv
// host controller: drives module enables, shutdown and status reads
////////////////////////////////////////////////////////////////////////////
// Functional notes
// - drive low to disable a module
// - release or drive high to enable
// - arrays are turned off by global shutdown
// - drop and re-raise request for new snapshot
// - release lines within 3 ms of request
// - lines meaningful only while valid high
// - drop request to return to enable mode
// - drive lines again 1 to 4 ms after drop
// - ignore status of unpopulated positions
// - status valid only for supporting families
module supply_host_ctrl
  import supply_ctrl_pkg::*;
#(
  parameter int unsigned MEASURE_CYCLES = MEASURE_CYC,
  parameter int unsigned RETURN_CYCLES  = RETURN_CYC,
  parameter int unsigned TIMEOUT_CYCLES = VALID_TO_CYC
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  // software register port
  input  wire supply_ctrl_pkg::bus_req_s bus_i,
  output logic            [31:0] rdata_o,
  // shared per-module lines (input, output, enable)
  input  wire logic        [5:0] line_i,
  output logic             [5:0] line_o,
  output logic             [5:0] line_oe_o,
  // status read request and valid flag
  output logic                   status_read_request_o,
  input  wire logic              status_valid_flag_i,
  // global shutdown, active low, open drain style
  output logic                   global_shutdown_o,
  output logic                   global_shutdown_oe_o
);
  import supply_ctrl_pkg::*;

  // elaboration checks: refuse counts the sequencer cannot serve
  if (RETURN_CYCLES < CLK_PER_US * RETURN_MIN_US ||
      RETURN_CYCLES > CLK_PER_US * RETURN_MAX_US) begin : g_bad_return
    $error("return delay outside the allowed window");
  end
  if (MEASURE_CYCLES == 0 ||
      TIMEOUT_CYCLES < MEASURE_CYCLES) begin : g_bad_wait
    $error("bad measurement or timeout count");
  end

  typedef enum logic [4:0] {
    S_IDLE    = 5'b00001,
    S_RELEASE = 5'b00010,
    S_WAIT    = 5'b00100,
    S_CAPTURE = 5'b01000,
    S_RETURN  = 5'b10000
  } phase_e;

  // one counter serves release, wait and return: size it for the longest
  localparam int unsigned CNT_TOP =
    (TIMEOUT_CYCLES > RETURN_CYCLES) ? TIMEOUT_CYCLES : RETURN_CYCLES;
  localparam int unsigned CW =
    $clog2(((CNT_TOP > RELEASE_CYC) ? CNT_TOP : RELEASE_CYC) + 1);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [6:0] pins_sync;
  logic [5:0] line_s;
  logic       valid_s;

  sync2 #(.W(7)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({status_valid_flag_i, line_i}),
    .sync_o    (pins_sync)
  );
  assign line_s  = pins_sync[5:0];
  assign valid_s = pins_sync[6];

  //////////////////////////////////////////////////////////////////////////
  // software registers and sequencer state
  logic [5:0]    en_r,     en_nxt;
  logic [5:0]    pop_r,    pop_nxt;
  logic          shdn_r,   shdn_nxt;
  logic [5:0]    snap_r,   snap_nxt;
  logic          done_r,   done_nxt;
  logic          tout_r,   tout_nxt;
  logic          go_r,     go_nxt;
  logic [CW-1:0] cnt_r,    cnt_nxt;
  logic [31:0]   rdata_r,  rdata_nxt;
  phase_e        phase_r,  phase_nxt;

  // register writes, sequencing and read data
  always_comb begin
    en_nxt    = en_r;
    pop_nxt   = pop_r;
    shdn_nxt  = shdn_r;
    snap_nxt  = snap_r;
    done_nxt  = done_r;
    tout_nxt  = tout_r;
    go_nxt    = go_r;
    cnt_nxt   = cnt_r;
    phase_nxt = phase_r;
    rdata_nxt = '0;
    if (bus_i.wr && bus_i.addr == ADDR_CTRL) begin
      en_nxt   = bus_i.wdata[CTRL_EN_LSB +: 6];
      pop_nxt  = bus_i.wdata[CTRL_POP_LSB +: 6];
      shdn_nxt = bus_i.wdata[CTRL_SHDN];
    end
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_CTRL: begin
          rdata_nxt[CTRL_EN_LSB +: 6]  = en_r;
          rdata_nxt[CTRL_SHDN]         = shdn_r;
          rdata_nxt[CTRL_POP_LSB +: 6] = pop_r;
        end
        ADDR_STATUS: begin
          rdata_nxt[ST_BUSY] = (phase_r != S_IDLE) | go_r;
          rdata_nxt[ST_DONE] = done_r;
          rdata_nxt[ST_TOUT] = tout_r;
        end
        ADDR_SNAP: begin
          rdata_nxt[5:0] = snap_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
    case (phase_r)
      S_IDLE: begin
        if (go_r) begin
          go_nxt    = 1'b0;
          done_nxt  = 1'b0;
          tout_nxt  = 1'b0;
          cnt_nxt   = CW'(RELEASE_CYC);
          phase_nxt = S_RELEASE;
        end
      end
      S_RELEASE: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == CW'(1)) begin
          cnt_nxt   = CW'(TIMEOUT_CYCLES);
          phase_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        cnt_nxt = cnt_r - 1'b1;
        if (valid_s) begin
          phase_nxt = S_CAPTURE;
        end else if (cnt_r == CW'(1)) begin
          tout_nxt  = 1'b1;
          cnt_nxt   = CW'(RETURN_CYCLES);
          phase_nxt = S_RETURN;
        end
      end
      S_CAPTURE: begin
        // mask unpopulated positions; bit n is line n+1 (slot by slot)
        if (valid_s)
          snap_nxt = line_s & pop_r;
        else
          snap_nxt = '0;
        done_nxt  = valid_s;
        tout_nxt  = ~valid_s;
        cnt_nxt   = CW'(RETURN_CYCLES);
        phase_nxt = S_RETURN;
      end
      S_RETURN: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == CW'(1))
          phase_nxt = S_IDLE;
      end
      default: phase_nxt = S_IDLE;
    endcase
    // a start written as the pending one is taken wins over the clear
    if (bus_i.wr && bus_i.addr == ADDR_CTRL && bus_i.wdata[CTRL_READ])
      go_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_r    <= EN_RST;
      pop_r   <= POP_RST;
      shdn_r  <= 1'b0;
      snap_r  <= '0;
      done_r  <= 1'b0;
      tout_r  <= 1'b0;
      go_r    <= 1'b0;
      cnt_r   <= '0;
      rdata_r <= '0;
      phase_r <= S_IDLE;
    end else begin
      en_r    <= en_nxt;
      pop_r   <= pop_nxt;
      shdn_r  <= shdn_nxt;
      snap_r  <= snap_nxt;
      done_r  <= done_nxt;
      tout_r  <= tout_nxt;
      go_r    <= go_nxt;
      cnt_r   <= cnt_nxt;
      rdata_r <= rdata_nxt;
      phase_r <= phase_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drive, registered so the pins never glitch
  logic [5:0] oe_r, oe_nxt;
  logic       req_r, req_nxt;
  logic       gsd_oe_r, gsd_oe_nxt;

  // lines driven only in enable mode; high is released, low is driven
  always_comb begin
    req_nxt    = (phase_nxt == S_RELEASE) || (phase_nxt == S_WAIT) ||
                 (phase_nxt == S_CAPTURE);
    // enabled lines float, so the device sees them as enabled
    oe_nxt     = (phase_nxt == S_IDLE) ? ~en_nxt : 6'h00;
    gsd_oe_nxt = shdn_nxt;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oe_r     <= '0;
      req_r    <= 1'b0;
      gsd_oe_r <= 1'b0;
    end else begin
      oe_r     <= oe_nxt;
      req_r    <= req_nxt;
      gsd_oe_r <= gsd_oe_nxt;
    end
  end

  assign line_o                = 6'h00;
  assign line_oe_o             = oe_r;
  assign status_read_request_o = req_r;
  assign global_shutdown_o     = 1'b0;
  assign global_shutdown_oe_o  = gsd_oe_r;
  assign rdata_o               = rdata_r;

  //////////////////////////////////////////////////////////////////////////
  // assertions
  property p_release;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(req_r) |-> ##[0:300] (oe_r == 6'h00);
  endproperty
  a_release: assert property (p_release)
    else $error("lines not released after request");

  property p_no_drive_in_read;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      req_r |-> (oe_r == 6'h00);
  endproperty
  a_no_drive_in_read: assert property (p_no_drive_in_read)
    else $error("lines driven during status read");

  property p_return_gap;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      $fell(req_r) |-> (oe_r == 6'h00) [*8];
  endproperty
  a_return_gap: assert property (p_return_gap)
    else $error("lines driven too soon after request drop");

  property p_capture;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (phase_r == S_CAPTURE && valid_s) |=>
        (snap_r == ($past(line_s) & $past(pop_r)));
  endproperty
  a_capture: assert property (p_capture)
    else $error("snapshot not captured from lines");

  property p_enable_map;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (phase_r == S_IDLE && phase_nxt == S_IDLE) |=> (oe_r == ~en_r);
  endproperty
  a_enable_map: assert property (p_enable_map)
    else $error("line drive does not follow enables");

  property p_shutdown;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      gsd_oe_r == shdn_r;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown not driven");

  property p_start;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (phase_r == S_IDLE && go_r) |=> req_r;
  endproperty
  a_start: assert property (p_start)
    else $error("request not raised on start");

  property p_drop_after_capture;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (phase_r == S_CAPTURE) |=> !req_r ##1 !req_r;
  endproperty
  a_drop_after_capture: assert property (p_drop_after_capture)
    else $error("request not dropped after snapshot");

  c_read: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    phase_r == S_CAPTURE && valid_s);
  c_tout: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(tout_r));
  c_shdn_read: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    req_r && gsd_oe_r);
endmodule

// ===== sim/supply_dev_model.sv
// device model: supply with six shared enable and status lines
module supply_dev_model #(
  parameter int unsigned MEAS_NS = 8000
) (
  // host side pins
  input  wire logic       req_i,
  input  wire logic [5:0] host_o_i,
  input  wire logic [5:0] host_oe_i,
  input  wire logic       shdn_o_i,
  input  wire logic       shdn_oe_i,
  // scenario controls
  input  wire logic [5:0] good_i,
  input  wire logic       alive_i,
  // resolved lines and module state
  output logic      [5:0] line_o,
  output logic            valid_o,
  output logic      [5:0] mod_on_o,
  output logic            err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] en_r;
  logic [5:0] snap_r;
  logic [5:0] line_dly;
  logic       in_read;
  logic       fall_seen;
  time        t_fall;
  //////////////////////////////////////////////////////////////////////////
  initial begin
    valid_o = 1'b0;
    err_o = 1'b0;
    snap_r = 6'h00;
    in_read = 1'b0;
    fall_seen = 1'b0;
    t_fall = 0;
  end
  // host pull-down wins; before valid the lines show the inverse so an
  // early sample by the host is caught
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (host_oe_i[i])
        line_o[i] = host_o_i[i];
      else if (req_i)
        line_o[i] = valid_o ? snap_r[i] : ~snap_r[i];
      else
        line_o[i] = 1'b1;
    end
  end
  // input filter: a line released as the request rises is not an enable
  assign #50 line_dly = line_o;
  // enables follow the lines only outside status mode
  always_latch begin
    if (!req_i) begin
      en_r <= line_dly;
    end
  end
  assign mod_on_o = en_r & good_i & {6{~(shdn_oe_i & ~shdn_o_i)}};
  // one snapshot per rising request, valid after the measurement
  always @(posedge req_i) begin
    snap_r = mod_on_o;
    in_read = 1'b1;
    #(MEAS_NS);
    if (req_i && alive_i) valid_o = 1'b1;
  end
  // leaving status mode drops valid and frees the lines
  always @(negedge req_i) begin
    valid_o = 1'b0;
    fall_seen = in_read;
    in_read = 1'b0;
    t_fall = $time;
  end
  // host must have let go of the lines once data is valid
  always @(posedge valid_o) begin
    if (host_oe_i !== 6'h00) err_o = 1'b1;
  end
  // host drives the lines again only 1 ms to 4 ms after the drop
  always @(posedge (|host_oe_i)) begin
    if (fall_seen && !req_i) begin
      if ($time - t_fall < 1_000_000 || $time - t_fall > 4_000_000)
        err_o = 1'b1;
      fall_seen = 1'b0;
    end
  end
endmodule

// ===== sim/tb.sv
// testbench: host controller against the device model
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import supply_ctrl_pkg::*;
  logic        ref_clk_i;
  logic        rst_b_i;
  bus_req_s    bus_r;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [5:0]  line_lvl;
  logic [5:0]  line_drv;
  logic [5:0]  line_oe;
  logic [5:0]  good;
  logic [5:0]  mod_on;
  logic        req;
  logic        gs_o;
  logic        gs_oe;
  logic        valid;
  logic        err;
  logic        alive;
  int          failures;
  int          checks;
  int          cyc;
  time         t_drop;
  //////////////////////////////////////////////////////////////////////////
  supply_host_ctrl #(
    .MEASURE_CYCLES(100),
    .RETURN_CYCLES (25000),
    .TIMEOUT_CYCLES(500)
  ) u_dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_i(bus_r),
    .rdata_o(rdata), .line_i(line_lvl), .line_o(line_drv),
    .line_oe_o(line_oe), .status_read_request_o(req),
    .status_valid_flag_i(valid), .global_shutdown_o(gs_o),
    .global_shutdown_oe_o(gs_oe)
  );
  supply_dev_model #(.MEAS_NS(8000)) u_dev (
    .req_i(req), .host_o_i(line_drv), .host_oe_i(line_oe),
    .shdn_o_i(gs_o), .shdn_oe_i(gs_oe), .good_i(good), .alive_i(alive),
    .line_o(line_lvl), .valid_o(valid), .mod_on_o(mod_on), .err_o(err)
  );
  //////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // time of each request drop, for the return window check
  always @(negedge req) t_drop = $time;
  // ceiling: three reads with their 1 ms return gap take about 76k cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // register port cycles; read data stands only in the cycle after rd
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    bus_r <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk_i);
    bus_r <= '0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    bus_r <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    bus_r <= '0;
    #1;
    d = rdata;
  endtask
  function automatic logic [31:0] ctrl(logic [5:0] en, logic sd, logic st,
                                       logic [5:0] pop);
    return {10'h000, pop, 6'h00, st, sd, 2'h0, en};
  endfunction
  // the model filters its lines, so leave a few cycles before looking
  task automatic settle();
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask
  // enables are set first so the request never races a line release
  task automatic start_read(input logic [5:0] en, input logic [5:0] pop);
    int n;
    wr(ADDR_CTRL, ctrl(en, 1'b0, 1'b0, pop));
    settle();
    wr(ADDR_CTRL, ctrl(en, 1'b0, 1'b1, pop));
    n = 0;
    while (req !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      n++;
    end
    #1;
    `CHK("request up", 1'b1, req)
    `CHK("line release", 6'h00, line_oe)
  endtask
  task automatic end_read(input logic [5:0] en, input int bitn,
                          input logic [5:0] exp);
    int n;
    time gap;
    n = 0;
    do begin
      rd(ADDR_STATUS);
      n++;
    end while (d[bitn] !== 1'b1 && n < 1000);
    `CHK("status", 1'b1, d[bitn])
    rd(ADDR_SNAP);
    `CHK("snapshot", {26'h0, exp}, d)
    n = 0;
    while (req !== 1'b0 && n < 100) begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHK("request down", 1'b0, req)
    n = 0;
    // look just after each edge so the restore is seen on its own edge
    while (line_oe !== ~en && n < 120000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    gap = $time - t_drop;
    `CHK("return gap", 1'b1, gap inside {[1_000_000:4_000_000]})
  endtask
  task automatic t_reset();
    rd(ADDR_CTRL);
    `CHK("ctrl reset", 32'h003F_003F, d)
    `CHK("oe reset", 6'h00, line_oe)
    rd(4'hC);
    `CHK("unmapped", 32'h0000_0000, d)
  endtask
  task automatic t_enable();
    wr(ADDR_CTRL, ctrl(6'h2D, 1'b0, 1'b0, 6'h3F));
    settle();
    `CHK("oe", 6'h12, line_oe)
    `CHK("modules on", 6'h2D, mod_on)
    wr(ADDR_CTRL, ctrl(6'h2D, 1'b1, 1'b0, 6'h3F));
    settle();
    `CHK("shutdown oe", 1'b1, gs_oe)
    `CHK("all off", 6'h00, mod_on)
    wr(ADDR_CTRL, ctrl(6'h2D, 1'b0, 1'b0, 6'h3F));
    settle();
    `CHK("shutdown free", 1'b0, gs_oe)
  endtask
  // faulty line 3, disabled line 2, unpopulated line 6, shutdown mid-read
  task automatic t_read1();
    good = 6'h3B;
    start_read(6'h3D, 6'h1F);
    wr(ADDR_CTRL, ctrl(6'h3D, 1'b1, 1'b0, 6'h1F));
    settle();
    `CHK("off in read", 6'h00, mod_on)
    wr(ADDR_CTRL, ctrl(6'h3D, 1'b0, 1'b0, 6'h1F));
    good = 6'h3F;
    end_read(6'h3D, ST_DONE, 6'h19);
  endtask
  initial begin
    rst_b_i = 1'b0;
    bus_r = '0;
    good = 6'h3F;
    alive = 1'b1;
    failures = 0;
    checks = 0;
    cyc = 0;
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_enable();
    t_read1();
    // a fresh request takes a fresh snapshot
    start_read(6'h1E, 6'h3F);
    end_read(6'h1E, ST_DONE, 6'h1E);
    // a silent device times out and leaves the old snapshot in place
    alive = 1'b0;
    start_read(6'h2B, 6'h3F);
    end_read(6'h2B, ST_TOUT, 6'h1E);
    `CHK("host timing", 1'b0, err)
    give_verdict();
  end
endmodule
